// ===== pkg/wdc_pkg.sv
// shared constants and types for the watchdog control block
package wdc_pkg;

  // clocking and oscillator emulation
  localparam int unsigned CLK_FREQ_HZ   = 50_000_000;
  localparam int unsigned OSC_FREQ_HZ   = 128_000;
  // oscillator period in whole system cycles, rounded down so it is never longer than nominal
  localparam int unsigned OSC_DIV       = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int unsigned DIV_W         = 9;

  // time-out counter
  localparam int unsigned BASE_TICKS    = 2048;
  localparam int unsigned CNT_W         = 21;
  localparam int unsigned PSEL_W        = 4;

  // change-enable window in system clock cycles
  localparam int unsigned CE_WINDOW_CYC = 4;
  localparam int unsigned CE_CNT_W      = 3;

  // register byte offsets on the bus
  localparam logic [3:0] CTRL_OFS       = 4'h0;
  localparam logic [3:0] STAT_OFS       = 4'h4;

  // control register field positions
  localparam int unsigned FLAG_BIT      = 7;
  localparam int unsigned IE_BIT        = 6;
  localparam int unsigned PSEL3_BIT     = 5;
  localparam int unsigned CE_BIT        = 4;
  localparam int unsigned WDE_BIT       = 3;
  localparam int unsigned PSEL_LO_MSB   = 2;

  // values after reset
  localparam logic [7:0] CTRL_RST       = 8'h00;
  localparam logic [3:0] PSEL_RST       = 4'h0;

  // operating modes of the watchdog
  typedef enum logic [2:0] {
    WDC_STOPPED  = 3'b000,
    WDC_IRQ      = 3'b001,
    WDC_RESET    = 3'b010,
    WDC_COMBINED = 3'b011
  } wdc_mode_t;

endpackage

// ===== pkg/wdc_tmr_if.sv
// carrier between the control logic, the tick divider and the time-out counter
`timescale 1ns/1ps
interface wdc_tmr_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic                      tick;
  logic                      restart;
  logic                      run;
  logic [wdc_pkg::PSEL_W-1:0] psel;
  logic                      timeout;

  modport gen (input clk, input rst_n, output tick);
  modport tmr (input clk, input rst_n, input tick, input restart, input run, input psel,
               output timeout);
  modport ctl (output restart, output run, output psel, input timeout);
endinterface

// ===== rtl/wdc_tick_gen.sv
// divider that turns the system clock into the watchdog oscillator tick
`timescale 1ns/1ps
module wdc_tick_gen (
  // timer carrier
  wdc_tmr_if.gen bus
);
  logic [wdc_pkg::DIV_W-1:0] div_r;
  logic [wdc_pkg::DIV_W-1:0] div_nxt;
  logic                      tick_r;
  logic                      tick_nxt;

  // free running, independent of every control bit
  always_comb begin
    div_nxt  = div_r + 1'b1;
    tick_nxt = 1'b0;
    if (div_r == wdc_pkg::DIV_W'(wdc_pkg::OSC_DIV - 1)) begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign bus.tick = tick_r;

  tick_spacing_a: assert property (@(posedge bus.clk) disable iff (!bus.rst_n)
    tick_r |=> !tick_r[*8]) else $error("oscillator ticks too close");
endmodule

// ===== rtl/wdc_counter.sv
// watchdog counter, counts oscillator ticks up to the selected period
`timescale 1ns/1ps
module wdc_counter #(
  parameter int unsigned BASE_TICKS = wdc_pkg::BASE_TICKS
) (
  // timer carrier
  wdc_tmr_if.tmr bus
);
  logic [wdc_pkg::CNT_W-1:0] cnt_r;
  logic [wdc_pkg::CNT_W-1:0] cnt_nxt;
  logic [wdc_pkg::CNT_W-1:0] limit;
  logic                      timeout_r;
  logic                      timeout_nxt;

  // reserved codes wrap the shift; their period is left undefined
  assign limit = wdc_pkg::CNT_W'(BASE_TICKS << bus.psel);

  always_comb begin
    cnt_nxt     = cnt_r;
    timeout_nxt = 1'b0;
    if (!bus.run || bus.restart) begin
      cnt_nxt = '0;
    end else if (bus.tick) begin
      // >= so a shorter period fires at once rather than wrapping
      if (cnt_r >= limit - 1'b1) begin
        cnt_nxt     = '0;
        timeout_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      cnt_r     <= '0;
      timeout_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  assign bus.timeout = timeout_r;

  period_len_a: assert property (@(posedge bus.clk) disable iff (!bus.rst_n)
    timeout_r |-> $past(cnt_r) >= $past(limit) - 1'b1) else $error("early time-out");
endmodule

// ===== rtl/wdc_top.sv
// watchdog timer control: register, mode decode, time-out actions, bus slave
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module wdc_top #(
  parameter int unsigned BASE_TICKS = wdc_pkg::BASE_TICKS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // cpu core side
  input  wire logic        wd_restart,
  input  wire logic        irq_vector_ack,
  input  wire logic        global_irq_enable,
  input  wire logic        watchdog_reset_cause_flag,
  // configuration levels
  input  wire logic        always_on_fuse,
  input  wire logic        clock_monitor_on,
  // results
  output logic             timeout_irq,
  output logic             system_reset_req
);

  wdc_tmr_if tif (
    .clk   (clk),
    .rst_n (rst_n)
  );

  wdc_tick_gen u_tick (
    .bus (tif.gen)
  );

  wdc_counter #(
    .BASE_TICKS (BASE_TICKS)
  ) u_cnt (
    .bus (tif.tmr)
  );

  // register state
  logic                         flag_r;
  logic                         flag_nxt;
  logic                         ie_r;
  logic                         ie_nxt;
  logic                         wde_r;
  logic                         wde_nxt;
  logic                         ce_r;
  logic                         ce_nxt;
  logic [wdc_pkg::CE_CNT_W-1:0] ce_cnt_r;
  logic [wdc_pkg::CE_CNT_W-1:0] ce_cnt_nxt;
  logic [wdc_pkg::PSEL_W-1:0]   psel_r;
  logic [wdc_pkg::PSEL_W-1:0]   psel_nxt;
  logic                         sysrst_r;
  logic                         sysrst_nxt;
  // bus state
  logic                         ack_r;
  logic                         ack_nxt;
  logic [7:0]                   rdata_r;
  logic [7:0]                   rdata_nxt;
  // decode
  logic                         wr_ctrl;
  logic [7:0]                   wd;
  logic                         forced_rst;
  logic                         wde_eff;
  logic                         ie_eff;
  logic                         flag_set;
  logic                         rst_fire;
  logic [7:0]                   ctrl_view;
  logic [7:0]                   stat_view;
  wdc_pkg::wdc_mode_t           mode;

  // one wait state: the answer always comes at the second edge of a request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = {24'h000000, rdata_r};
  assign wd              = avs_writedata[7:0];
  assign wr_ctrl         = avs_write & ack_r & (avs_address == wdc_pkg::CTRL_OFS)
                           & avs_byteenable[0];

  // fuse always pins the unit in reset mode; the monitor does so only while the watchdog is enabled
  assign forced_rst = always_on_fuse | clock_monitor_on;
  // effective bits, so forcing shows at once and not a cycle later
  assign wde_eff    = wde_r | always_on_fuse | watchdog_reset_cause_flag;
  assign ie_eff     = ie_r & ~forced_rst;

  always_comb begin
    if (!always_on_fuse && !wde_eff && !ie_r) begin
      mode = wdc_pkg::WDC_STOPPED;
    end else if (forced_rst) begin
      mode = wdc_pkg::WDC_RESET;
    end else begin
      case ({wde_eff, ie_r})
        2'b01:   mode = wdc_pkg::WDC_IRQ;
        2'b11:   mode = wdc_pkg::WDC_COMBINED;
        default: mode = wdc_pkg::WDC_RESET;
      endcase
    end
  end

  assign tif.run     = (mode != wdc_pkg::WDC_STOPPED);
  assign tif.restart = wd_restart;
  assign tif.psel    = psel_r;

  always_comb begin
    flag_set = 1'b0;
    rst_fire = 1'b0;
    if (tif.timeout) begin
      case (mode)
        wdc_pkg::WDC_IRQ:      flag_set = 1'b1;
        wdc_pkg::WDC_COMBINED: begin
          // flag still up means the vector was never taken
          if (flag_r) begin
            rst_fire = 1'b1;
          end else begin
            flag_set = 1'b1;
          end
        end
        wdc_pkg::WDC_RESET:    rst_fire = 1'b1;
        default:               rst_fire = 1'b0;
      endcase
    end
  end

  always_comb begin
    flag_nxt   = flag_r;
    ie_nxt     = ie_r;
    wde_nxt    = wde_r;
    ce_nxt     = ce_r;
    ce_cnt_nxt = ce_cnt_r;
    psel_nxt   = psel_r;
    sysrst_nxt = rst_fire;

    // flag: hardware set beats either clear
    if (irq_vector_ack) begin
      flag_nxt = 1'b0;
    end
    if (wr_ctrl && wd[wdc_pkg::FLAG_BIT]) begin
      flag_nxt = 1'b0;
    end
    if (flag_set) begin
      flag_nxt = 1'b1;
    end

    // interrupt enable; re-arming is left to software
    if (wr_ctrl) begin
      ie_nxt = wd[wdc_pkg::IE_BIT];
    end
    if (irq_vector_ack && wde_eff) begin
      ie_nxt = 1'b0;
    end
    // monitor only masks the interrupt; a written enable still arms reset
    if (always_on_fuse) begin
      ie_nxt = 1'b0;
    end

    // reset enable: setting is free, clearing needs the open window
    if (wr_ctrl) begin
      if (wd[wdc_pkg::WDE_BIT]) begin
        wde_nxt = 1'b1;
      end else if (ce_r) begin
        wde_nxt = 1'b0;
      end
    end
    if (always_on_fuse || watchdog_reset_cause_flag) begin
      wde_nxt = 1'b1;
    end

    // period select only moves inside the window
    if (wr_ctrl && ce_r) begin
      psel_nxt = {wd[wdc_pkg::PSEL3_BIT], wd[wdc_pkg::PSEL_LO_MSB:0]};
    end

    // change enable window
    if (ce_r) begin
      ce_cnt_nxt = ce_cnt_r + 1'b1;
      if (ce_cnt_r == wdc_pkg::CE_CNT_W'(wdc_pkg::CE_WINDOW_CYC - 1)) begin
        ce_nxt     = 1'b0;
        ce_cnt_nxt = '0;
      end
    end
    if (wr_ctrl) begin
      // opening needs reset enable written one in the same access
      ce_nxt     = wd[wdc_pkg::CE_BIT] & wd[wdc_pkg::WDE_BIT];
      ce_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r   <= wdc_pkg::CTRL_RST[wdc_pkg::FLAG_BIT];
      ie_r     <= wdc_pkg::CTRL_RST[wdc_pkg::IE_BIT];
      wde_r    <= wdc_pkg::CTRL_RST[wdc_pkg::WDE_BIT];
      ce_r     <= wdc_pkg::CTRL_RST[wdc_pkg::CE_BIT];
      ce_cnt_r <= '0;
      psel_r   <= wdc_pkg::PSEL_RST;
      sysrst_r <= 1'b0;
    end else begin
      flag_r   <= flag_nxt;
      ie_r     <= ie_nxt;
      wde_r    <= wde_nxt;
      ce_r     <= ce_nxt;
      ce_cnt_r <= ce_cnt_nxt;
      psel_r   <= psel_nxt;
      sysrst_r <= sysrst_nxt;
    end
  end

  assign ctrl_view = {flag_r, ie_eff, psel_r[3], ce_r, wde_eff, psel_r[2:0]};
  assign stat_view = {4'h0, forced_rst, mode};

  always_comb begin
    ack_nxt   = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      if (avs_address == wdc_pkg::CTRL_OFS) begin
        rdata_nxt = ctrl_view;
      end else if (avs_address == wdc_pkg::STAT_OFS) begin
        rdata_nxt = stat_view;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r   <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign timeout_irq      = flag_r & ie_eff & global_irq_enable;
  assign system_reset_req = sysrst_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  flag_on_timeout_a: assert property (
    tif.timeout && mode == wdc_pkg::WDC_IRQ |=> flag_r && !system_reset_req)
    else $error("interrupt time-out did not set flag");

  vector_clears_a: assert property (
    irq_vector_ack && !flag_set |=> !flag_r)
    else $error("vector entry left flag set");

  write_one_a: assert property (
    wr_ctrl && !flag_set && wd[wdc_pkg::FLAG_BIT] |=> !flag_r)
    else $error("write one did not clear flag");

  write_zero_a: assert property (
    wr_ctrl && flag_r && !wd[wdc_pkg::FLAG_BIT] && !irq_vector_ack |=> flag_r)
    else $error("write zero cleared flag");

  irq_gate_a: assert property (
    timeout_irq |-> global_irq_enable && ie_r && flag_r && !clock_monitor_on)
    else $error("interrupt raised without all enables");

  irq_only_a: assert property (
    mode == wdc_pkg::WDC_IRQ && tif.timeout |=> !system_reset_req ##1 !system_reset_req)
    else $error("interrupt mode reset the system");

  combined_first_a: assert property (
    mode == wdc_pkg::WDC_COMBINED && tif.timeout && !flag_r |=> flag_r && !system_reset_req)
    else $error("first combined time-out misbehaved");

  combined_vector_a: assert property (
    irq_vector_ack && wde_eff && !wr_ctrl |=> !ie_r)
    else $error("vector did not drop interrupt enable");

  combined_second_a: assert property (
    mode == wdc_pkg::WDC_COMBINED && tif.timeout && flag_r |=> system_reset_req ##1
    !system_reset_req)
    else $error("unserviced time-out gave no single reset pulse");

  monitor_mode_a: assert property (
    clock_monitor_on && (wde_eff || ie_r || always_on_fuse) |->
    mode == wdc_pkg::WDC_RESET && !timeout_irq)
    else $error("clock monitor did not force reset mode");

  stopped_quiet_a: assert property (
    mode == wdc_pkg::WDC_STOPPED |=> !system_reset_req)
    else $error("stopped watchdog acted");

  fuse_lock_a: assert property (
    always_on_fuse && $past(always_on_fuse) |-> wde_r && !ie_r)
    else $error("fuse did not lock enables");

  period_lock_a: assert property (
    wr_ctrl && !ce_r |=> $stable(psel_r))
    else $error("period changed outside window");

  window_len_a: assert property (
    ($rose(ce_r) && !wr_ctrl) ##1 (!wr_ctrl) [*3] |-> ce_r ##1 !ce_r)
    else $error("change enable outlived window");

  cause_hold_a: assert property (
    watchdog_reset_cause_flag |=> wde_r)
    else $error("reset enable dropped while cause flag set");

  period_map_a: assert property (
    wr_ctrl && ce_r |=> psel_r == {$past(avs_writedata[5]), $past(avs_writedata[2:0])})
    else $error("period select bits mapped wrongly");

endmodule

// ===== verification/tb_wdc_top.sv
// self-checking bench for the watchdog control block, driven over avalon-mm
`timescale 1ns/1ps
module tb_wdc_top;
  localparam int BT = 4;
  localparam int TK = wdc_pkg::OSC_DIV;
  localparam logic [3:0] CT = wdc_pkg::CTRL_OFS;
  localparam logic [3:0] ST = wdc_pkg::STAT_OFS;
  logic        clk            = 1'b0;
  logic        rst_n          = 1'b0;
  logic [3:0]  avs_address    = 4'h0;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        wd_restart     = 1'b0;
  logic        irq_vector_ack = 1'b0;
  logic        gie            = 1'b0;
  logic        cause          = 1'b0;
  logic        fuse           = 1'b0;
  logic        mon            = 1'b0;
  logic        timeout_irq;
  logic        system_reset_req;
  int          n_mismatch     = 0;
  int          cmp_count      = 0;
  int          n_rst          = 0;
  int          n;
  int          r0;

  wdc_top #(.BASE_TICKS(BT)) i_wdc_top (
    .clk                       (clk),
    .rst_n                     (rst_n),
    .avs_address               (avs_address),
    .avs_read                  (avs_read),
    .avs_write                 (avs_write),
    .avs_writedata             (avs_writedata),
    .avs_byteenable            (avs_byteenable),
    .avs_readdata              (avs_readdata),
    .avs_waitrequest           (avs_waitrequest),
    .wd_restart                (wd_restart),
    .irq_vector_ack            (irq_vector_ack),
    .global_irq_enable         (gie),
    .watchdog_reset_cause_flag (cause),
    .always_on_fuse            (fuse),
    .clock_monitor_on          (mon),
    .timeout_irq               (timeout_irq),
    .system_reset_req          (system_reset_req)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  // registered pulse, so the pre-edge value is the one of the cycle just ended
  always @(posedge clk) begin
    if (system_reset_req === 1'b1) n_rst++;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi, input int v);
    cmp_count++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  // enter right after a rising edge; request is left up for back-to-back use
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    logic w;
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h0, d};
    w = 1'b1;
    // sampled at the rising edge itself, before that edge's updates land
    while (w !== 1'b0) begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
    end
  endtask

  task automatic idle();
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    idle();
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    idle();
    chk($sformatf("reg %h", a), {24'h0, e}, q & {24'hffffff, m});
  endtask

  // timed change sequence: open the window, then the wanted value at once
  task automatic win(input logic [7:0] d1, input logic [7:0] d2);
    logic [31:0] q;
    bus(1'b1, CT, d1, q);
    bus(1'b1, CT, d2, q);
    idle();
  endtask

  // one-cycle strobe: 0 restarts the counter, 1 enters the vector
  task automatic pulse(input bit vec);
    if (vec) begin
      irq_vector_ack <= 1'b1;
    end else begin
      wd_restart <= 1'b1;
    end
    @(posedge clk);
    irq_vector_ack <= 1'b0;
    wd_restart     <= 1'b0;
    @(posedge clk);
  endtask

  // waits for the interrupt level (sel 0) or the reset pulse (sel 1)
  task automatic wait_hi(input bit sel, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while ((sel ? system_reset_req : timeout_irq) !== 1'b1 && k < 4000);
    @(posedge clk);
    if (k >= 4000) chk("wait expired", 32'h1, 32'h0);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset state, unmapped place, ignored lane
    rchk(CT, 8'hff, 8'h00);
    rchk(ST, 8'h07, 8'h00);
    wr(4'h8, 8'hff);
    rchk(4'h8, 8'hff, 8'h00);
    avs_byteenable <= 4'h0;
    wr(CT, 8'h40);
    avs_byteenable <= 4'hf;
    rchk(CT, 8'hff, 8'h00);
    repeat (2000) @(posedge clk);
    chk("stopped reset", 32'h0, n_rst);
    chk("stopped irq", 32'h0, {31'h0, timeout_irq});
    $display("test reset done");
    // always-on fuse
    fuse <= 1'b1;
    wr(CT, 8'h40);
    rchk(CT, 8'hff, 8'h08);
    rchk(ST, 8'h07, 8'h02);
    wait_hi(1'b1, n);
    chk("fuse irq", 32'h0, {31'h0, timeout_irq});
    fuse <= 1'b0;
    win(8'h18, 8'h80);
    rchk(CT, 8'hff, 8'h00);
    $display("test fuse done");
    // interrupt-only mode, flag handling, period codes 0 and 1
    gie <= 1'b1;
    wr(CT, 8'h40);
    r0 = n_rst;
    pulse(1'b0);
    wait_hi(1'b0, n);
    rng("period 0", (BT - 1) * TK, BT * TK + 8, n + 2);
    rchk(CT, 8'hff, 8'hc0);
    rchk(ST, 8'h07, 8'h01);
    gie <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("irq masked", 32'h0, {31'h0, timeout_irq});
    @(posedge clk);
    wr(CT, 8'h40);
    rchk(CT, 8'hff, 8'hc0);
    wr(CT, 8'hc0);
    rchk(CT, 8'hff, 8'h40);
    gie <= 1'b1;
    wait_hi(1'b0, n);
    pulse(1'b1);
    rchk(CT, 8'hff, 8'h40);
    chk("irq mode reset", r0, n_rst);
    wr(CT, 8'h41);
    rchk(CT, 8'hff, 8'h40);
    pulse(1'b0);
    win(8'h58, 8'h41);
    rchk(CT, 8'hff, 8'h41);
    pulse(1'b0);
    wait_hi(1'b0, n);
    rng("period 1", (2 * BT - 1) * TK, 2 * BT * TK + 8, n + 2);
    pulse(1'b1);
    $display("test irq mode done");
    // change window closes by itself
    wr(CT, 8'h59);
    repeat (6) @(posedge clk);
    rchk(CT, 8'hff, 8'h49);
    wr(CT, 8'h41);
    rchk(CT, 8'hff, 8'h49);
    $display("test window done");
    // combined mode: unserviced, then serviced
    rchk(ST, 8'h07, 8'h03);
    r0 = n_rst;
    pulse(1'b0);
    wait_hi(1'b0, n);
    chk("first timeout reset", r0, n_rst);
    wait_hi(1'b1, n);
    rng("second timeout", (2 * BT - 1) * TK, 2 * BT * TK + 8, n + 2);
    chk("irq after reset", 32'h1, {31'h0, timeout_irq});
    pulse(1'b0);
    pulse(1'b1);
    rchk(CT, 8'hc8, 8'h08);
    rchk(ST, 8'h07, 8'h02);
    wait_hi(1'b1, n);
    chk("reset mode irq", 32'h0, {31'h0, timeout_irq});
    wr(CT, 8'h48);
    rchk(ST, 8'h07, 8'h03);
    $display("test combined done");
    // reset-cause flag pins the reset enable
    cause <= 1'b1;
    win(8'h18, 8'h80);
    rchk(CT, 8'h08, 8'h08);
    cause <= 1'b0;
    win(8'h18, 8'h80);
    rchk(CT, 8'hff, 8'h00);
    $display("test cause flag done");
    // clock monitor forces reset mode
    mon <= 1'b1;
    rchk(ST, 8'h07, 8'h00);
    wr(CT, 8'h40);
    rchk(CT, 8'h40, 8'h00);
    rchk(ST, 8'h07, 8'h02);
    pulse(1'b0);
    wait_hi(1'b1, n);
    chk("monitor irq", 32'h0, {31'h0, timeout_irq});
    mon <= 1'b0;
    $display("test monitor done");
    results();
  end
endmodule
